// ---- hdl/epw_map.svh ----
`ifndef EPW_MAP_SVH
`define EPW_MAP_SVH

// Register byte offsets on the Avalon-MM slave, one aligned word each.
`define EPW_OFF_TIMEBASE   5'h00
`define EPW_OFF_PERIOD     5'h04
`define EPW_OFF_TB_CTRL    5'h08
`define EPW_OFF_DUTY_LOW   5'h0C
`define EPW_OFF_DUTY_ACT   5'h10
`define EPW_OFF_ENH_CTRL   5'h14
`define EPW_OFF_STATUS     5'h18

// Field positions.
`define EPW_TB_ON_BIT      2
`define EPW_TB_CKPS_LSB    0
`define EPW_TB_POST_LSB    3
`define EPW_EC_CFG_LSB     6
`define EPW_EC_DLSB_LSB    4
`define EPW_EC_MODE_LSB    0
`define EPW_ST_MATCH_BIT   0
`define EPW_ST_POST_BIT    1

// Reset values.
`define EPW_RST_BYTE       8'h00
`define EPW_RST_TB_CTRL    7'h00
`define EPW_RST_PERIOD     8'hFF

// Mode codes of the enhanced control register.
`define EPW_MODE_OFF       4'h0
`define EPW_MODE_RSV1      4'h1
`define EPW_MODE_TOGGLE    4'h2
`define EPW_MODE_RSV3      4'h3
`define EPW_MODE_CAP_FALL  4'h4
`define EPW_MODE_CAP_RISE  4'h5
`define EPW_MODE_CAP_4TH   4'h6
`define EPW_MODE_CAP_16TH  4'h7
`define EPW_MODE_CMP_SET   4'h8
`define EPW_MODE_CMP_CLR   4'h9
`define EPW_MODE_CMP_SWI   4'hA
`define EPW_MODE_CMP_SPEC  4'hB

// Output configurations in PWM mode.
`define EPW_CFG_SINGLE     2'h0
`define EPW_CFG_FULL_FWD   2'h1
`define EPW_CFG_HALF       2'h2
`define EPW_CFG_FULL_REV   2'h3

// Last value of the prescaler counter: four oscillator phases times 1, 4 or 16; then of the capture edge counter.
`define EPW_PSC_LIM_1      6'h03
`define EPW_PSC_LIM_4      6'h0F
`define EPW_PSC_LIM_16     6'h3F
`define EPW_CAP_LIM_4TH    4'h3
`define EPW_CAP_LIM_16TH   4'hF

`endif

// ---- hdl/epw_pkg.sv ----
package epw_pkg;

  typedef enum logic [1:0] {
    EPW_IDLE = 2'b01,
    EPW_ACK  = 2'b10
  } epw_bus_e;

  typedef struct packed {
    logic [3:0] level;
    logic [3:0] own;
  } epw_pins_s;

  typedef struct packed {
    epw_bus_e   bus;
    logic       waitreq;
    logic [7:0] rdata;
    logic [7:0] tmr;
    logic [7:0] pr;
    logic [6:0] tcon;
    logic [7:0] dlow;
    logic [7:0] dact;
    logic [1:0] dlsb;
    logic [7:0] econ;
    logic [1:0] cfg_act;
    logic [1:0] pol_act;
    logic [5:0] psc;
    logic [3:0] post;
    logic       pwm_lvl;
    logic       cmp_lvl;
    logic [1:0] flags;
    logic       cap_s1;
    logic       cap_s2;
    logic       cap_prev;
    logic [3:0] cap_cnt;
    epw_pins_s  pins;
    logic       tmr_rst;
    logic       adc_trig;
    logic       cap_evt;
  } epw_state_s;

endpackage

// ---- hdl/epw_core.sv ----
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "epw_map.svh"
// How it works
// - Period comes from a written period register compared against the timebase counter.
// - Tick after count equals period: clear counter, set output unless duty zero, load duty.
// - Postscaler never shapes the period; it only raises a slower event flag.
// - Duty is ten bits: low-byte register above control bits five and four.
// - Duty writes apply at next period match; active duty byte read-only in PWM.
// - Active byte plus a two-bit latch double-buffer the duty, so no glitches.
// - Output drops when buffered duty equals count extended by two-bit sub-count.
// - Duty beyond the period never drops the output in that period.
// - Outside PWM, configuration bits ignored; first pin compare, others port pins.
// - Config 00 modulates first pin only; 10 modulates first and second pins.
// - Full-bridge forward modulates fourth pin; reverse modulates second, as configured.
// - Control bits five and four are duty bits only in PWM mode.
// - Mode 0000 turns the unit off and resets it; 0001 and 0011 reserved.
// - Compare modes: 0010 toggles, 1000 sets, 1001 clears; last two raise flag.
// - Capture on falling, rising, every fourth or every sixteenth rising edge.
// - Mode 1010 raises only the flag; the pin returns to port control.
// - Mode 1011 match resets the external timer, sets flag, starts a conversion.
// - Codes 1100 to 1111 are PWM; bits one and zero invert pin pairs.
// - Clearing the control register forces the output latch low.
module epw_core (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        cmp_match,
  input  wire logic        capture_pin,
  output logic      [3:0]  pwm_out,
  output logic      [3:0]  pin_owned,
  output logic             timer_reset,
  output logic             adc_trigger,
  output logic             capture_event
);

  epw_pkg::epw_state_s s_q;
  epw_pkg::epw_state_s s_d;

  logic [3:0] mode;
  logic       pwm_mode;
  logic       ton;
  logic       tick;
  logic       boundary;
  logic [1:0] sub;
  logic [9:0] duty_buf;
  logic [9:0] duty_new;
  logic       duty_hit;
  logic       cap_rise;
  logic       cap_fall;

  function automatic logic is_pwm(input logic [3:0] m);
    is_pwm = (m[3:2] == 2'b11);
  endfunction

  function automatic logic [5:0] psc_limit(input logic [1:0] ckps);
    case (ckps)
      2'b00:   psc_limit = `EPW_PSC_LIM_1;
      2'b01:   psc_limit = `EPW_PSC_LIM_4;
      default: psc_limit = `EPW_PSC_LIM_16;
    endcase
  endfunction

  // The sub-count is the oscillator phase at prescale 1, otherwise prescaler bits.
  function automatic logic [1:0] sub_count(input logic [5:0] p, input logic [1:0] ckps);
    case (ckps)
      2'b00:   sub_count = p[1:0];
      2'b01:   sub_count = p[3:2];
      default: sub_count = p[5:4];
    endcase
  endfunction

  function automatic logic is_off(input logic [3:0] m);
    is_off = (m == `EPW_MODE_OFF) || (m == `EPW_MODE_RSV1) || (m == `EPW_MODE_RSV3);
  endfunction

  assign mode     = s_q.econ[`EPW_EC_MODE_LSB +: 4];
  assign pwm_mode = is_pwm(mode);
  assign ton      = s_q.tcon[`EPW_TB_ON_BIT];
  assign tick     = ton && (s_q.psc == psc_limit(s_q.tcon[`EPW_TB_CKPS_LSB +: 2]));
  assign boundary = tick && (s_q.tmr == s_q.pr);
  assign sub      = sub_count(s_q.psc, s_q.tcon[`EPW_TB_CKPS_LSB +: 2]);
  assign duty_buf = {s_q.dact, s_q.dlsb};
  assign duty_new = {s_q.dlow, s_q.econ[`EPW_EC_DLSB_LSB +: 2]};
  assign duty_hit = ton && ({s_q.tmr, sub} == duty_buf);
  assign cap_rise = s_q.cap_s2 && !s_q.cap_prev;
  assign cap_fall = !s_q.cap_s2 && s_q.cap_prev;

  always_comb begin
    logic [1:0] set_f;
    logic [1:0] clr_f;
    logic [7:0] wbyte;
    logic [3:0] lvl;
    logic [3:0] own;
    set_f = 2'b00;
    clr_f = 2'b00;
    wbyte = avs_writedata[7:0];
    lvl   = 4'h0;
    own   = 4'h0;
    s_d   = s_q;
    if (ce) begin
      s_d.tmr_rst  = 1'b0;
      s_d.adc_trig = 1'b0;
      s_d.cap_evt  = 1'b0;
      s_d.cap_s1   = capture_pin;
      s_d.cap_s2   = s_q.cap_s1;
      s_d.cap_prev = s_q.cap_s2;

      // Timebase: prescaler, counter and period boundary.
      if (ton) begin
        s_d.psc = tick ? 6'h00 : 6'(s_q.psc + 6'h01);
      end
      if (pwm_mode && duty_hit) begin
        s_d.pwm_lvl = 1'b0;
      end
      if (boundary) begin
        s_d.tmr     = 8'h00;
        s_d.dact    = s_q.dlow;
        s_d.dlsb    = s_q.econ[`EPW_EC_DLSB_LSB +: 2];
        s_d.cfg_act = s_q.econ[`EPW_EC_CFG_LSB +: 2];
        s_d.pol_act = s_q.econ[1:0];
        s_d.pwm_lvl = pwm_mode && (duty_new != 10'h000);
        // The postscaler only counts boundaries and never touches the counter.
        if (s_q.post == s_q.tcon[`EPW_TB_POST_LSB +: 4]) begin
          s_d.post = 4'h0;
          set_f[`EPW_ST_POST_BIT] = 1'b1;
        end else begin
          s_d.post = 4'(s_q.post + 4'h1);
        end
      end else if (tick) begin
        s_d.tmr = 8'(s_q.tmr + 8'h01);
      end

      // Compare actions on a match from the external sixteen-bit timer.
      if (cmp_match) begin
        case (mode)
          `EPW_MODE_TOGGLE: begin
            s_d.cmp_lvl = !s_q.cmp_lvl;
          end
          `EPW_MODE_CMP_SET: begin
            s_d.cmp_lvl = 1'b1;
            set_f[`EPW_ST_MATCH_BIT] = 1'b1;
          end
          `EPW_MODE_CMP_CLR: begin
            s_d.cmp_lvl = 1'b0;
            set_f[`EPW_ST_MATCH_BIT] = 1'b1;
          end
          `EPW_MODE_CMP_SWI: begin
            set_f[`EPW_ST_MATCH_BIT] = 1'b1;
          end
          `EPW_MODE_CMP_SPEC: begin
            set_f[`EPW_ST_MATCH_BIT] = 1'b1;
            s_d.tmr_rst  = 1'b1;
            s_d.adc_trig = 1'b1;
          end
          default: begin
          end
        endcase
      end

      // Capture edge selection and edge prescaling.
      case (mode)
        `EPW_MODE_CAP_FALL: begin
          s_d.cap_evt = cap_fall;
        end
        `EPW_MODE_CAP_RISE: begin
          s_d.cap_evt = cap_rise;
        end
        `EPW_MODE_CAP_4TH, `EPW_MODE_CAP_16TH: begin
          if (cap_rise) begin
            if (s_q.cap_cnt == ((mode == `EPW_MODE_CAP_4TH) ? `EPW_CAP_LIM_4TH
                                                             : `EPW_CAP_LIM_16TH)) begin
              s_d.cap_cnt = 4'h0;
              s_d.cap_evt = 1'b1;
            end else begin
              s_d.cap_cnt = 4'(s_q.cap_cnt + 4'h1);
            end
          end
        end
        default: begin
          s_d.cap_cnt = 4'h0;
        end
      endcase
      if (s_d.cap_evt) begin
        set_f[`EPW_ST_MATCH_BIT] = 1'b1;
      end

      // Pin steering; a duty match masks the level in its own cycle, so high time is exact.
      if (pwm_mode) begin
        case (s_q.cfg_act)
          `EPW_CFG_SINGLE: begin
            lvl = {3'b000, s_q.pwm_lvl && !duty_hit};
            own = 4'b0001;
          end
          `EPW_CFG_HALF: begin
            lvl = {2'b00, !(s_q.pwm_lvl && !duty_hit), s_q.pwm_lvl && !duty_hit};
            own = 4'b0011;
          end
          `EPW_CFG_FULL_FWD: begin
            lvl = {s_q.pwm_lvl && !duty_hit, 2'b00, 1'b1};
            own = 4'b1111;
          end
          default: begin
            lvl = {1'b0, 1'b1, s_q.pwm_lvl && !duty_hit, 1'b0};
            own = 4'b1111;
          end
        endcase
        for (int i = 0; i < 4; i++) begin
          lvl[i] = lvl[i] ^ s_q.pol_act[(i % 2 == 0) ? 1 : 0];
        end
      end else if (mode == `EPW_MODE_TOGGLE || mode == `EPW_MODE_CMP_SET ||
                   mode == `EPW_MODE_CMP_CLR || mode == `EPW_MODE_CMP_SPEC) begin
        lvl = {3'b000, s_q.cmp_lvl};
        own = 4'b0001;
      end
      s_d.pins.level = lvl;
      s_d.pins.own   = own;

      // Avalon-MM slave: take a request in idle, answer one cycle later.
      case (s_q.bus)
        epw_pkg::EPW_IDLE: begin
          if (avs_read || avs_write) begin
            s_d.bus     = epw_pkg::EPW_ACK;
            s_d.waitreq = 1'b0;
            case (avs_address)
              `EPW_OFF_TIMEBASE: s_d.rdata = s_q.tmr;
              `EPW_OFF_PERIOD:   s_d.rdata = s_q.pr;
              `EPW_OFF_TB_CTRL:  s_d.rdata = {1'b0, s_q.tcon};
              `EPW_OFF_DUTY_LOW: s_d.rdata = s_q.dlow;
              `EPW_OFF_DUTY_ACT: s_d.rdata = s_q.dact;
              `EPW_OFF_ENH_CTRL: s_d.rdata = s_q.econ;
              `EPW_OFF_STATUS:   s_d.rdata = {6'h00, s_q.flags};
              default:           s_d.rdata = 8'h00;
            endcase
          end
        end
        epw_pkg::EPW_ACK: begin
          s_d.bus     = epw_pkg::EPW_IDLE;
          s_d.waitreq = 1'b1;
          if (avs_write && avs_byteenable[0]) begin
            case (avs_address)
              `EPW_OFF_TIMEBASE: begin
                s_d.tmr = wbyte;
                s_d.psc = 6'h00;
              end
              `EPW_OFF_PERIOD: begin
                s_d.pr = wbyte;
              end
              `EPW_OFF_TB_CTRL: begin
                s_d.tcon = wbyte[6:0];
              end
              `EPW_OFF_DUTY_LOW: begin
                s_d.dlow = wbyte;
              end
              `EPW_OFF_DUTY_ACT: begin
                if (!pwm_mode) begin
                  s_d.dact = wbyte;
                end
              end
              `EPW_OFF_ENH_CTRL: begin
                s_d.econ = wbyte;
                case (wbyte[3:0])
                  `EPW_MODE_CMP_SET: s_d.cmp_lvl = 1'b0;
                  `EPW_MODE_CMP_CLR: s_d.cmp_lvl = 1'b1;
                  default: begin
                    if (is_off(wbyte[3:0])) begin
                      s_d.cmp_lvl = 1'b0;
                      s_d.pwm_lvl = 1'b0;
                      s_d.cap_cnt = 4'h0;
                    end
                  end
                endcase
              end
              `EPW_OFF_STATUS: begin
                clr_f = wbyte[1:0];
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
          s_d.bus     = epw_pkg::EPW_IDLE;
          s_d.waitreq = 1'b1;
        end
      endcase
      // A flag event in the same cycle as its clear is kept.
      s_d.flags = (s_q.flags & ~clr_f) | set_f;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s_q         <= '0;
      s_q.bus     <= epw_pkg::EPW_IDLE;
      s_q.waitreq <= 1'b1;
      s_q.pr      <= `EPW_RST_PERIOD;
      s_q.tcon    <= `EPW_RST_TB_CTRL;
      s_q.econ    <= `EPW_RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  assign avs_readdata    = {24'h000000, s_q.rdata};
  assign avs_waitrequest = s_q.waitreq;
  assign pwm_out         = s_q.pins.level;
  assign pin_owned       = s_q.pins.own;
  assign timer_reset     = s_q.tmr_rst;
  assign adc_trigger     = s_q.adc_trig;
  assign capture_event   = s_q.cap_evt;

  property p_wrap;
    @(posedge mclk) disable iff (reset)
      ce && boundary |=> s_q.tmr == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter not cleared at period match");

  property p_load;
    @(posedge mclk) disable iff (reset)
      ce && boundary |=> s_q.dact == $past(s_q.dlow) && s_q.pwm_lvl == $past(pwm_mode &&
                          duty_new != 10'h000);
  endproperty
  a_load: assert property (p_load) else $error("duty not loaded or output not set");

  property p_hold;
    @(posedge mclk) disable iff (reset)
      ce && pwm_mode && !boundary |=> $stable(s_q.dact) && $stable(s_q.dlsb);
  endproperty
  a_hold: assert property (p_hold) else $error("active duty changed mid-period");

  property p_drop;
    @(posedge mclk) disable iff (reset)
      ce && pwm_mode && duty_hit && !boundary |=> !s_q.pwm_lvl ##1 (!ce || !s_q.pins.level[0]
                          || s_q.pol_act[1] || s_q.cfg_act != `EPW_CFG_SINGLE);
  endproperty
  a_drop: assert property (p_drop) else $error("output not dropped at duty match");

  property p_nonpwm;
    @(posedge mclk) disable iff (reset)
      ce && !pwm_mode |=> s_q.pins.own[3:1] == 3'b000;
  endproperty
  a_nonpwm: assert property (p_nonpwm) else $error("extra pins claimed outside PWM");

  property p_single;
    @(posedge mclk) disable iff (reset)
      ce && pwm_mode && s_q.cfg_act == `EPW_CFG_SINGLE |=> s_q.pins.own == 4'b0001;
  endproperty
  a_single: assert property (p_single) else $error("single output steering wrong");

  property p_fwd;
    @(posedge mclk) disable iff (reset)
      ce && pwm_mode && s_q.cfg_act == `EPW_CFG_FULL_FWD |=> s_q.pins.own == 4'b1111 &&
        s_q.pins.level[0] == !$past(s_q.pol_act[1]) && s_q.pins.level[1] == $past(s_q.pol_act[0]);
  endproperty
  a_fwd: assert property (p_fwd) else $error("forward bridge levels wrong");

  property p_swi;
    @(posedge mclk) disable iff (reset)
      ce && mode == `EPW_MODE_CMP_SWI && cmp_match |=> s_q.flags[0] && s_q.pins.own == 4'h0;
  endproperty
  a_swi: assert property (p_swi) else $error("software interrupt mode wrong");

  property p_spec;
    @(posedge mclk) disable iff (reset)
      ce && mode == `EPW_MODE_CMP_SPEC && cmp_match |=> timer_reset && adc_trigger && s_q.flags[0]
        ##1 (!ce || !timer_reset);
  endproperty
  a_spec: assert property (p_spec) else $error("special event trigger wrong");

  property p_off;
    @(posedge mclk) disable iff (reset)
      ce && is_off(mode) [*2] |=> pin_owned == 4'h0 && pwm_out == 4'h0 && !s_q.cmp_lvl;
  endproperty
  a_off: assert property (p_off) else $error("off mode still drives pins");

  property p_cmpset;
    @(posedge mclk) disable iff (reset)
      ce && mode == `EPW_MODE_CMP_SET && cmp_match |=> s_q.cmp_lvl && s_q.flags[0];
  endproperty
  a_cmpset: assert property (p_cmpset) else $error("compare set mode wrong");

  property p_caprise;
    @(posedge mclk) disable iff (reset)
      ce && mode == `EPW_MODE_CAP_RISE && cap_rise |=> capture_event;
  endproperty
  a_caprise: assert property (p_caprise) else $error("rising capture missed");

endmodule

// ---- dv/epw_load_model.sv ----
`timescale 1ns/100ps
module epw_load_model (
  input  wire logic        mclk,
  input  wire logic [3:0]  pwm_out,
  input  wire logic [3:0]  pin_owned,
  output logic      [3:0]  pin_lvl,
  output logic             meas_vld,
  output logic      [31:0] meas
);
  logic [15:0] hi_n  = 16'h0000;
  logic [15:0] per_n = 16'h0000;
  logic        prev  = 1'b0;

  // A pin the unit does not drive is a port pin, pulled low at the load.
  assign pin_lvl = pwm_out & pin_owned;

  // Each rising edge of the first pin reports the last period and high time.
  initial meas_vld = 1'b0;
  initial meas = 32'h0000_0000;
  always @(posedge mclk) begin
    meas_vld <= 1'b0;
    prev     <= pin_lvl[0];
    per_n    <= per_n + 16'h0001;
    if (pin_lvl[0]) begin
      hi_n <= hi_n + 16'h0001;
    end
    if (pin_lvl[0] && !prev) begin
      meas_vld <= 1'b1;
      meas     <= {per_n, hi_n};
      per_n    <= 16'h0001;
      hi_n     <= 16'h0001;
    end
  end
endmodule

// ---- dv/test_ccp_pwm_with_enhanced_control.sv ----
`timescale 1ns/100ps
`include "epw_map.svh"
module test_ccp_pwm_with_enhanced_control;
  logic        mclk           = 1'b0;
  logic        reset          = 1'b1;
  logic        ce             = 1'b1;
  logic [4:0]  avs_address    = 5'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic        cmp_match      = 1'b0;
  logic        capture_pin    = 1'b0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [3:0]  pwm_out;
  logic [3:0]  pin_owned;
  logic [3:0]  pin_lvl;
  logic        timer_reset;
  logic        adc_trigger;
  logic        capture_event;
  logic        meas_vld;
  logic [31:0] meas;
  logic [31:0] seed = 32'hE18F20F6;
  logic [7:0]  d;
  logic [7:0]  m;
  logic        b;
  logic        hit;
  int          err_count = 0;
  int          checked = 0;
  int          n_cap = 0;
  logic [7:0]  rd_q[$];
  logic [31:0] pw_q[$];
  logic [7:0]  cfg_t[4] = '{8'h0C, 8'h8C, 8'h4C, 8'hCF};
  logic [3:0]  own_t[4] = '{4'h1, 4'h3, 4'hF, 4'hF};
  logic [3:0]  msk_t[4] = '{4'h0, 4'h0, 4'h7, 4'hD};
  logic [3:0]  val_t[4] = '{4'h0, 4'h0, 4'h1, 4'h9};

  always #2.5 mclk = ~mclk;

  epw_core DUT (.mclk, .reset, .ce, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .cmp_match, .capture_pin,
    .pwm_out, .pin_owned, .timer_reset, .adc_trigger, .capture_event);

  epw_load_model LOAD (.mclk, .pwm_out, .pin_owned, .pin_lvl, .meas_vld, .meas);

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic fail();
    err_count++;
    finish_test();
  endtask

  // One Avalon access: held until waitrequest is sampled low, then released.
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] v,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address    <= a;
    avs_writedata  <= {24'h0, v};
    avs_byteenable <= be;
    avs_read       <= !wr;
    avs_write      <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) fail();
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    bus(1'b1, a, v, 4'h1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 8'h00, 4'h1);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic pulse();
    @(posedge mclk);
    cmp_match <= 1'b1;
    @(posedge mclk);
    cmp_match <= 1'b0;
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    cyc(10);
    reset <= 1'b0;
  endtask

  // Monitor: every read answer takes the oldest note off rd_q; a pulse report takes one off pw_q while it holds any.
  always @(posedge mclk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      if (rd_q.size() == 0) check("read note", 32'h1, 32'h0);
      else check("readdata", avs_readdata, {24'h0, rd_q.pop_front()});
    end
    if (meas_vld === 1'b1 && pw_q.size() > 0) begin
      check("pulse", meas, pw_q.pop_front());
    end
    if (capture_event === 1'b1) n_cap++;
  end

  initial begin
    #400000;
    fail();
  end

  initial begin
    do_reset();
    rd(`EPW_OFF_PERIOD, 8'hFF);
    rd(`EPW_OFF_ENH_CTRL, 8'h00);
    rd(`EPW_OFF_TIMEBASE, 8'h00);
    rd(`EPW_OFF_DUTY_LOW, 8'h00);
    rd(5'h1C, 8'h00);
    check("own", 32'(pin_owned), 32'h0);
    bus(1'b1, `EPW_OFF_PERIOD, 8'h03, 4'h0);
    rd(`EPW_OFF_PERIOD, 8'hFF);
    // Setup in the prescribed order; a postscale of 8 must not change the period.
    wr(`EPW_OFF_PERIOD, 8'h03);
    wr(`EPW_OFF_DUTY_LOW, 8'h01);
    wr(`EPW_OFF_TB_CTRL, 8'h3C);
    wr(`EPW_OFF_ENH_CTRL, 8'h2C);
    cyc(48);
    check("own single", 32'(pin_owned), 32'h1);
    for (int i = 0; i < 4; i++) begin
      d = 8'h01 + 8'(rnd() % 14);
      wr(`EPW_OFF_DUTY_LOW, d >> 2);
      wr(`EPW_OFF_ENH_CTRL, {2'b00, d[1:0], 4'hC});
      cyc(40);
      pw_q.push_back({16'h0010, 8'h00, d});
      pw_q.push_back({16'h0010, 8'h00, d});
      for (int n = 0; n < 300 && pw_q.size() > 0; n++) @(posedge mclk);
      if (pw_q.size() > 0) fail();
    end
    // The postscaler has counted boundaries into its own flag only.
    rd(`EPW_OFF_STATUS, 8'h02);
    wr(`EPW_OFF_TB_CTRL, 8'h00);
    wr(`EPW_OFF_DUTY_LOW, 8'h02);
    rd(`EPW_OFF_DUTY_ACT, d >> 2);
    wr(`EPW_OFF_DUTY_ACT, 8'h55);
    rd(`EPW_OFF_DUTY_ACT, d >> 2);
    wr(`EPW_OFF_TB_CTRL, 8'h04);
    cyc(40);
    rd(`EPW_OFF_DUTY_ACT, 8'h02);
    for (int k = 0; k < 2; k++) begin
      wr(`EPW_OFF_DUTY_LOW, k ? 8'h00 : 8'h20);
      wr(`EPW_OFF_ENH_CTRL, 8'h0C);
      cyc(40);
      for (int n = 0; n < 40; n++) begin
        @(negedge mclk);
        check("level", 32'(pwm_out[0]), 32'(!k));
      end
    end
    wr(`EPW_OFF_DUTY_LOW, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(`EPW_OFF_ENH_CTRL, cfg_t[i]);
      cyc(40);
      check("own cfg", 32'(pin_owned), 32'(own_t[i]));
      check("held pins", 32'(pwm_out & msk_t[i]), 32'(val_t[i]));
    end
    // Compare modes with the configuration bits set, which must be ignored.
    for (int i = 0; i < 3; i++) begin
      m = (i == 0) ? 8'h08 : (i == 1) ? 8'h09 : 8'h02;
      wr(`EPW_OFF_ENH_CTRL, 8'hC0 | m);
      cyc(8);
      check("own cmp", 32'(pin_owned), 32'h1);
      if (m != 8'h02) check("init", 32'(pwm_out[0]), 32'(m == 8'h09));
      b = pwm_out[0];
      pulse();
      cyc(4);
      check("match", 32'(pwm_out[0]), 32'((m == 8'h08) | ((m == 8'h02) & !b)));
    end
    wr(`EPW_OFF_TB_CTRL, 8'h00);
    wr(`EPW_OFF_STATUS, 8'h03);
    wr(`EPW_OFF_ENH_CTRL, 8'h0B);
    pulse();
    hit = 1'b0;
    for (int n = 0; n < 6; n++) begin
      @(negedge mclk);
      if (timer_reset === 1'b1 && adc_trigger === 1'b1) hit = 1'b1;
    end
    check("special event", 32'(hit), 32'h1);
    rd(`EPW_OFF_STATUS, 8'h01);
    wr(`EPW_OFF_STATUS, 8'h03);
    wr(`EPW_OFF_ENH_CTRL, 8'h01);
    pulse();
    cyc(4);
    rd(`EPW_OFF_STATUS, 8'h00);
    check("own rsv", 32'(pin_owned), 32'h0);
    wr(`EPW_OFF_ENH_CTRL, 8'h0A);
    pulse();
    cyc(4);
    check("own swi", 32'(pin_owned[0]), 32'h0);
    rd(`EPW_OFF_STATUS, 8'h01);
    wr(`EPW_OFF_ENH_CTRL, 8'h00);
    cyc(4);
    check("off pins", 32'({pin_owned, pwm_out}), 32'h0);
    for (int i = 4; i < 8; i++) begin
      wr(`EPW_OFF_ENH_CTRL, 8'h00);
      wr(`EPW_OFF_ENH_CTRL, 8'(i));
      n_cap = 0;
      repeat ((i == 7) ? 16 : 4) begin
        @(posedge mclk);
        capture_pin <= 1'b1;
        cyc(8);
        capture_pin <= 1'b0;
        cyc(8);
      end
      cyc(8);
      check("captures", 32'(n_cap), (i > 5) ? 32'h1 : 32'h4);
    end
    // A pin pulse that comes and goes while the clock enable is low is never seen.
    wr(`EPW_OFF_ENH_CTRL, 8'h05);
    n_cap = 0;
    ce          <= 1'b0;
    capture_pin <= 1'b1;
    cyc(8);
    capture_pin <= 1'b0;
    cyc(8);
    ce <= 1'b1;
    cyc(8);
    check("frozen", 32'(n_cap), 32'h0);
    do_reset();
    rd(`EPW_OFF_PERIOD, 8'hFF);
    rd(`EPW_OFF_ENH_CTRL, 8'h00);
    finish_test();
  end
endmodule
